// ---- hw/atbm_defines.vh ----
/*
  Shared constants for the AT-style bus master: timing counts, operation codes
  and bus cycle lengths.
  Assumes a 125 MHz system clock; nothing else.
*/
`ifndef ATBM_DEFINES_VH
`define ATBM_DEFINES_VH

`define ATBM_CLK_MHZ         125
`define ATBM_BCLK_DIV        16
`define ATBM_CMD_CLKS        6
`define ATBM_ALE_CLKS        2
`define ATBM_REF_PERIOD_US   15
`define ATBM_REF_CLKS        ((`ATBM_REF_PERIOD_US * `ATBM_CLK_MHZ))
`define ATBM_BEEP_MAX_HZ     2000
`define ATBM_BEEP_HALF_CLKS  ((`ATBM_CLK_MHZ * 1000000 + `ATBM_BEEP_MAX_HZ * 2 - 1) / (`ATBM_BEEP_MAX_HZ * 2))
`define ATBM_RST_HOLD_CLKS   64
`define ATBM_OP_MEM          2'h0
`define ATBM_OP_IO           2'h1
`define ATBM_OP_DMA_IO       2'h2

`endif

// ---- hw/atbm_master.v ----
/*
  AT-style expansion bus master: issues memory, I/O and DMA-style I/O
  cycles, refresh cycles, reset drive and the key beep pulse train.
  Assumes a single 125 MHz clock, synchronous active-high reset, and
  targets that follow the usual command/ready handshake.
*/
// Summary of operation
// - Reset drive high at power-up, falling edge
// - Memory write/read strobes active low
// - I/O write/read strobes active low
// - Master issues periodic refresh cycles
// - Beep pulse train no faster than 2 kHz
// - High byte enable marks upper lane use
// - Unlatched address valid while ALE high
// - Address transparent during ALE, then latched
// - Data bus sixteen bits, bit 0 LSB
// - Address enable low on DMA cycles
`timescale 1ns/100ps
`include "atbm_defines.vh"

module atbm_master #(
  parameter REF_CLKS  = `ATBM_REF_CLKS,
  parameter BEEP_HALF = `ATBM_BEEP_HALF_CLKS
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        power_low,
  input  wire        req_valid,
  input  wire [1:0]  req_op,
  input  wire        req_write,
  input  wire [23:0] req_addr,
  input  wire [15:0] req_wdata,
  input  wire        req_word,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  input  wire        beep_enable,
  output reg         key_beep_pulse,
  output reg         reset_drv,
  output reg         bale,
  output reg         aen,
  output reg         refresh_n,
  output reg         memw_n,
  output reg         memr_n,
  output reg         iowr_n,
  output reg         iord_n,
  output reg  [19:0] sa,
  output reg  [23:17] la,
  output reg         sbhe_n,
  output reg  [15:0] sd_out,
  output reg         sd_oe,
  input  wire [15:0] sd_in,
  input  wire        iochrdy,
  input  wire        memcs16_n,
  input  wire [2:0]  irq_in,
  output reg  [2:0]  irq_seen
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ALE  = 3'h1;
  localparam ST_CMD  = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam ST_REF  = 3'h5;

  reg [2:0]  st_q;
  reg [3:0]  bclk_q;
  reg        bclk_fall_q;
  reg [7:0]  rst_cnt_q;
  reg [3:0]  cyc_q;
  reg [31:0] ref_cnt_q;
  reg        ref_pend_q;
  reg [31:0] beep_cnt_q;
  reg        write_q;
  reg        word_q;
  reg        is_mem_q;
  reg [2:0]  rdy_s1_q, rdy_s2_q, rdy_s3_q;
  reg [2:0]  irq_s1_q, irq_s2_q, irq_s3_q;
  reg [15:0] sd_s1_q, sd_s2_q, sd_s3_q;
  reg        pwr_s1_q, pwr_s2_q, pwr_s3_q, pwr_low_q;

  // Ready and 16-bit select come off pins, so they cross via three stages
  wire rdy_ok    = rdy_s2_q[0] & rdy_s3_q[0];
  wire cs16_lo   = ~rdy_s2_q[1] & ~rdy_s3_q[1];
  wire drv_start = bclk_fall_q & pwr_low_q;

  function cmd_done;
    input [3:0] cnt;
    begin
      cmd_done = (cnt >= `ATBM_CMD_CLKS);
    end
  endfunction

  always @(posedge clk)
  begin
    rdy_s1_q <= {1'b0, memcs16_n, iochrdy};
    rdy_s2_q <= rdy_s1_q;
    rdy_s3_q <= rdy_s2_q;
    irq_s1_q <= irq_in;
    irq_s2_q <= irq_s1_q;
    irq_s3_q <= irq_s2_q;
    sd_s1_q  <= sd_in;
    sd_s2_q  <= sd_s1_q;
    sd_s3_q  <= sd_s2_q;
    pwr_s1_q <= power_low;
    pwr_s2_q <= pwr_s1_q;
    pwr_s3_q <= pwr_s2_q;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      irq_seen  <= 3'h0;
      pwr_low_q <= 1'b0;
    end
    else
    begin
      if (irq_s2_q == irq_s3_q)
        irq_seen <= irq_s3_q;
      if (pwr_s2_q == pwr_s3_q)
        pwr_low_q <= pwr_s3_q;
    end
  end

  // Bus clock divider; its falling-edge enable times the reset drive
  always @(posedge clk)
  begin
    if (rst)
    begin
      bclk_q      <= 4'h0;
      bclk_fall_q <= 1'b0;
    end
    else
    begin
      bclk_q      <= bclk_q + 4'h1;
      bclk_fall_q <= (bclk_q == (`ATBM_BCLK_DIV / 2 - 1));
    end
  end

  // Reset drive held for a fixed span, changed only on falling edges or by rst
  always @(posedge clk)
  begin
    if (rst)
    begin
      reset_drv <= 1'b1;
      rst_cnt_q <= 8'h00;
    end
    else if (bclk_fall_q)
    begin
      if (pwr_low_q)
      begin
        reset_drv <= 1'b1;
        rst_cnt_q <= 8'h00;
      end
      else if (rst_cnt_q < `ATBM_RST_HOLD_CLKS)
      begin
        rst_cnt_q <= rst_cnt_q + 8'h01;
      end
      else
      begin
        reset_drv <= 1'b0;
      end
    end
  end

  // Beep toggles at a half period that keeps it at or under 2 kHz
  always @(posedge clk)
  begin
    if (rst | ~beep_enable)
    begin
      beep_cnt_q     <= 32'h0;
      key_beep_pulse <= 1'b0;
    end
    else if (beep_cnt_q >= BEEP_HALF - 1)
    begin
      beep_cnt_q     <= 32'h0;
      key_beep_pulse <= ~key_beep_pulse;
    end
    else
    begin
      beep_cnt_q <= beep_cnt_q + 32'h1;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      ref_cnt_q  <= 32'h0;
      ref_pend_q <= 1'b0;
    end
    else
    begin
      // A pending refresh set in the same cycle it is taken still wins
      if (ref_cnt_q >= REF_CLKS - 1)
      begin
        ref_cnt_q  <= 32'h0;
        ref_pend_q <= 1'b1;
      end
      else
      begin
        ref_cnt_q <= ref_cnt_q + 32'h1;
        if (st_q == ST_IDLE && ref_pend_q && !(req_valid & req_ready) && !reset_drv)
        begin
          ref_pend_q <= 1'b0;
        end
      end
    end
  end

  always @(posedge clk)
  begin
    if (rst | reset_drv | drv_start)
    begin
      st_q      <= ST_IDLE;
      cyc_q     <= 4'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      bale      <= 1'b0;
      aen       <= 1'b1;
      refresh_n <= 1'b1;
      memw_n    <= 1'b1;
      memr_n    <= 1'b1;
      iowr_n    <= 1'b1;
      iord_n    <= 1'b1;
      sa        <= 20'h00000;
      la        <= 7'h00;
      sbhe_n    <= 1'b1;
      sd_out    <= 16'h0000;
      sd_oe     <= 1'b0;
      write_q   <= 1'b0;
      word_q    <= 1'b0;
      is_mem_q  <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          cyc_q     <= 4'h0;
          req_ready <= ~ref_pend_q;
          if (req_valid & req_ready)
          begin
            req_ready <= 1'b0;
            bale      <= 1'b1;
            sa        <= req_addr[19:0];
            la        <= req_addr[23:17];
            sbhe_n    <= ~(req_word | req_addr[0]);
            aen       <= (req_op != `ATBM_OP_DMA_IO);
            write_q   <= req_write;
            word_q    <= req_word;
            is_mem_q  <= (req_op == `ATBM_OP_MEM);
            sd_out    <= req_addr[0] ? {req_wdata[7:0], 8'h00} : req_wdata;
            st_q      <= ST_ALE;
          end
          else if (ref_pend_q)
          begin
            refresh_n <= 1'b0;
            memr_n    <= 1'b0;
            st_q      <= ST_REF;
          end
        end
        ST_ALE:
        begin
          cyc_q <= cyc_q + 4'h1;
          if (cyc_q == `ATBM_ALE_CLKS - 1)
          begin
            // Address held latched from here; upper lines no longer valid
            bale  <= 1'b0;
            cyc_q <= 4'h0;
            sd_oe <= write_q;
            memw_n <= ~(is_mem_q & write_q);
            memr_n <= ~(is_mem_q & ~write_q);
            iowr_n <= ~(~is_mem_q & write_q);
            iord_n <= ~(~is_mem_q & ~write_q);
            st_q   <= ST_CMD;
          end
        end
        ST_CMD:
        begin
          cyc_q <= cyc_q + 4'h1;
          // 8-bit memory targets on a word request only get the low lane
          if (is_mem_q & word_q & ~cs16_lo)
          begin
            sbhe_n <= 1'b1;
          end
          if (cmd_done(cyc_q))
          begin
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (rdy_ok)
          begin
            rsp_rdata <= sd_s3_q;
            st_q      <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          memw_n    <= 1'b1;
          memr_n    <= 1'b1;
          iowr_n    <= 1'b1;
          iord_n    <= 1'b1;
          sd_oe     <= 1'b0;
          sbhe_n    <= 1'b1;
          aen       <= 1'b1;
          rsp_valid <= 1'b1;
          st_q      <= ST_IDLE;
        end
        ST_REF:
        begin
          cyc_q <= cyc_q + 4'h1;
          if (cmd_done(cyc_q) & rdy_ok)
          begin
            refresh_n <= 1'b1;
            memr_n    <= 1'b1;
            st_q      <= ST_IDLE;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- verification/atbm_properties.sv ----
/* Pin timing checker for the bus master.
   Bound to atbm_master, sees its ports only. */
`timescale 1ns/100ps
module atbm_properties #(
  parameter BEEP_HALF = 8
) (
  input wire        clk,
  input wire        rst,
  input wire        req_ready,
  input wire        beep_enable,
  input wire        key_beep_pulse,
  input wire        reset_drv,
  input wire        bale,
  input wire        aen,
  input wire        refresh_n,
  input wire        memw_n,
  input wire        memr_n,
  input wire        iowr_n,
  input wire        iord_n,
  input wire [19:0] sa,
  input wire        sd_oe,
  input wire        iochrdy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire       cmd = !(memr_n & memw_n & iowr_n & iord_n);
  reg        beep_q;
  reg [15:0] beep_cnt_q;
  // Held at full count while disabled, so a late enable never trips the check
  always @(posedge clk)
  begin
    beep_q <= key_beep_pulse;
    if (rst || !beep_enable)
      beep_cnt_q <= 16'(BEEP_HALF);
    else if (key_beep_pulse != beep_q)
      beep_cnt_q <= 16'h0000;
    else if (beep_cnt_q < BEEP_HALF)
      beep_cnt_q <= beep_cnt_q + 16'h0001;
  end
  strobe_excl_a: assert property ($onehot0({~memw_n, ~memr_n, ~iowr_n, ~iord_n}))
    else $error("two bus strobes low together");
  reset_idle_a: assert property (reset_drv |-> !cmd && !sd_oe && !req_ready && !bale)
    else $error("bus not idle during reset drive");
  refresh_only_a: assert property (!refresh_n |-> memw_n && iowr_n && iord_n && !sd_oe)
    else $error("refresh mixed with other command");
  ale_width_a: assert property ($rose(bale) |=> bale ##1 !bale)
    else $error("address latch pulse width wrong");
  cmd_after_ale_a: assert property (bale |-> !cmd)
    else $error("command during address latch");
  addr_hold_a: assert property (cmd && $past(cmd) |-> $stable(sa))
    else $error("address moved during command");
  write_drive_a: assert property ((!memw_n || !iowr_n) |-> sd_oe)
    else $error("write without data drive");
  read_float_a: assert property ((!memr_n || !iord_n) |-> !sd_oe)
    else $error("data driven during read");
  ready_wait_a: assert property ((!iochrdy && cmd) [*4] |=> cmd)
    else $error("command ended while not ready");
  beep_rate_a: assert property (key_beep_pulse != beep_q |-> beep_cnt_q >= BEEP_HALF - 1)
    else $error("beep toggles too fast");
  dma_no_mem_a: assert property (!aen |-> memr_n && memw_n && refresh_n)
    else $error("address enable low on memory cycle");
  cover property ($fell(memw_n));
  cover property (!aen && $fell(iowr_n));
  cover property ($fell(refresh_n));
  cover property (!iochrdy && !memr_n);
endmodule
bind atbm_master atbm_properties #(.BEEP_HALF(BEEP_HALF)) atbm_properties_i (.*);

// ---- verification/atbm_target.sv ----
/* Far-side model: small word memory, one I/O register, ready stretch.
   Assumes the master's pins and a wait count from the bench. */
`timescale 1ns/100ps
module atbm_target (
  input  wire         clk,
  input  wire         memw_n,
  input  wire         memr_n,
  input  wire         iowr_n,
  input  wire         iord_n,
  input  wire         aen,
  input  wire         bale,
  input  wire [23:17] la,
  input  wire [19:0]  sa,
  input  wire         sbhe_n,
  input  wire [15:0]  sd_out,
  input  wire [3:0]   wait_clks,
  input  wire [2:0]   irq_drv,
  output reg  [15:0]  sd_in,
  output wire         iochrdy,
  output wire         memcs16_n,
  output wire [2:0]   irq_in
);
  reg [15:0] mem [0:15];
  reg [7:0]  csr_q;
  reg [6:0]  la_q;
  reg [3:0]  wait_q;
  wire       cmd = !(memr_n & memw_n & iowr_n & iord_n);
  initial sd_in = 16'h0000;
  assign memcs16_n = (la_q != 7'h00);
  assign iochrdy = (wait_q >= wait_clks);
  assign irq_in = irq_drv;
  always @(posedge clk)
  begin
    if (bale)
      la_q <= la;
    wait_q <= !cmd ? 4'h0 : (wait_q == 4'hF) ? wait_q : wait_q + 4'h1;
    if (!memw_n && la_q == 7'h00 && !sa[0])
      mem[sa[4:1]][7:0] <= sd_out[7:0];
    if (!memw_n && la_q == 7'h00 && !sbhe_n)
      mem[sa[4:1]][15:8] <= sd_out[15:8];
    if (!iowr_n && aen && sa[9:0] == 10'h300)
      csr_q <= sd_out[7:0];
    // Released bus shows the inverse so stale data never passes
    if (!memr_n)
      sd_in <= mem[sa[4:1]];
    else if (!iord_n && aen)
      sd_in <= {8'h00, csr_q};
    else
      sd_in <= ~sd_in;
  end
endmodule

// ---- verification/tb_top.sv ----
/* Self-checking bench for the bus master with a target model.
   Assumes shortened refresh and beep counts. */
`timescale 1ns/100ps
module tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         power_low = 1'b0;
  reg         req_valid = 1'b0;
  reg  [1:0]  req_op = 2'h0;
  reg         req_write = 1'b0;
  reg  [23:0] req_addr = 24'h000000;
  reg  [15:0] req_wdata = 16'h0000;
  reg         req_word = 1'b0;
  reg         beep_enable = 1'b0;
  reg  [3:0]  wait_clks = 4'h0;
  reg  [2:0]  irq_drv = 3'h0;
  wire        req_ready, rsp_valid, key_beep_pulse, reset_drv, bale, aen, refresh_n;
  wire        memw_n, memr_n, iowr_n, iord_n, sbhe_n, sd_oe, iochrdy, memcs16_n;
  wire [15:0] rsp_rdata, sd_out, sd_in;
  wire [19:0] sa;
  wire [23:17] la;
  wire [2:0]  irq_in, irq_seen;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     cycles = 0;
  integer     k;
  reg  [15:0] rd;
  reg         sbhe_seen;
  reg         b;
  atbm_master #(.REF_CLKS(50), .BEEP_HALF(8)) atbm_master_i (.*);
  atbm_target atbm_target_i (.*);
  always #4 clk = ~clk;
  always @(posedge clk)
    if (!memw_n)
      sbhe_seen <= sbhe_n;
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task check(input [8*10-1:0] what, input [15:0] exp, input [15:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task bus(input [1:0] op, input wr, input [23:0] a, input [15:0] d, input w);
  begin
    k = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 3000)
    begin
      k = k + 1;
      @(negedge clk);
    end
    req_op = op;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_word = w;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 300)
    begin
      k = k + 1;
      @(negedge clk);
    end
    check("response", 16'h0001, {15'h0000, rsp_valid});
    rd = rsp_rdata;
  end
  endtask
  task t_mem;
  begin
    bus(2'h0, 1'b1, 24'h000004, 16'hA55A, 1'b1);
    check("sbhe word", 16'h0000, {15'h0000, sbhe_seen});
    wait_clks = 4'h6;
    bus(2'h0, 1'b0, 24'h000004, 16'h0000, 1'b1);
    check("mem word", 16'hA55A, rd);
    wait_clks = 4'h0;
    bus(2'h0, 1'b1, 24'h000004, 16'h00C3, 1'b0);
    check("sbhe byte", 16'h0001, {15'h0000, sbhe_seen});
    bus(2'h0, 1'b0, 24'h000004, 16'h0000, 1'b1);
    check("mem byte", 16'hA5C3, rd);
    bus(2'h0, 1'b1, 24'h020004, 16'h1234, 1'b1);
    check("sbhe 8bit", 16'h0001, {15'h0000, sbhe_seen});
    bus(2'h0, 1'b0, 24'h000004, 16'h0000, 1'b1);
    check("mem decode", 16'hA5C3, rd);
    $display("test mem done");
  end
  endtask
  task t_io;
  begin
    bus(2'h1, 1'b1, 24'h000300, 16'h0077, 1'b0);
    bus(2'h2, 1'b1, 24'h000300, 16'h0011, 1'b0);
    bus(2'h1, 1'b0, 24'h000300, 16'h0000, 1'b0);
    check("io reg", 16'h0077, rd);
    irq_drv = 3'h5;
    repeat (20) @(negedge clk);
    check("irq", 16'h0005, {13'h0000, irq_seen});
    $display("test io done");
  end
  endtask
  task t_timing;
  begin
    beep_enable = 1'b1;
    repeat (2)
    begin
      b = key_beep_pulse;
      k = 0;
      while (key_beep_pulse === b && k < 100)
      begin
        k = k + 1;
        @(negedge clk);
      end
    end
    check("beep half", 16'h0001, {15'h0000, k >= 8 && k < 100});
    k = 0;
    while (refresh_n !== 1'b0 && k < 200)
    begin
      k = k + 1;
      @(negedge clk);
    end
    check("refresh", 16'h0000, {15'h0000, memr_n});
    power_low = 1'b1;
    repeat (40) @(negedge clk);
    power_low = 1'b0;
    repeat (100) @(negedge clk);
    check("reset drv", 16'h0001, {15'h0000, reset_drv});
    bus(2'h1, 1'b0, 24'h000300, 16'h0000, 1'b0);
    $display("test timing done");
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("reset drv", 16'h0001, {15'h0000, reset_drv});
    t_mem;
    t_io;
    t_timing;
    print_verdict;
  end
endmodule
